//--- src/twbpe_pkg.sv
// package for the two-wire bus protocol engine: constants, states and carriers
`default_nettype none
package twbpe_pkg;
    localparam int          SYNC_STAGES  = 2;
    localparam int          BIT_CNT_W    = 4;
    localparam logic [3:0]  BITS_PER_PKT = 4'h9;
    localparam logic [3:0]  ACK_BIT_IDX  = 4'h8;
    localparam logic [15:0] LOW_CNT_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam int          T_LOW_NS     = 4800;
    localparam int          T_HIGH_NS    = 4000;
    localparam int          CLK_NS       = 8;
    localparam int          LOW_CYC      = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int          HIGH_CYC     = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        TWBPE_IDLE    = 4'b0000,
        TWBPE_START   = 4'b0001,
        TWBPE_LOW     = 4'b0010,
        TWBPE_HIGH    = 4'b0011,
        TWBPE_STRETCH = 4'b0100,
        TWBPE_STOP_A  = 4'b0101,
        TWBPE_STOP_B  = 4'b0110,
        TWBPE_LOST    = 4'b0111,
        TWBPE_RSTART  = 4'b1000
    } twbpe_state_t;

    typedef struct packed {
        logic       start;
        logic [6:0] addr;
        logic       read;
    } twbpe_cmd_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } twbpe_word_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } twbpe_pins_t;
endpackage
`default_nettype wire

//--- src/twbpe_engine.sv
// two-wire bus master protocol engine with transmit fifo and line sampling
`default_nettype none

// ****************************************************************
// fifo
// ****************************************************************
module twbpe_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wp_next  = push ? wp_reg + 1'b1 : wp_reg;
        rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rp_reg];
endmodule

// ****************************************************************
// engine
// ****************************************************************
module twbpe_engine #(
    parameter int LOW_CYCLES  = twbpe_pkg::LOW_CYC,
    parameter int HIGH_CYCLES = twbpe_pkg::HIGH_CYC,
    parameter int FIFO_DEPTH  = 16
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // command: address and direction
    input  wire twbpe_pkg::twbpe_cmd_t cmd,
    output logic                       cmd_ready,
    // write data stream
    input  wire logic                  wr_valid,
    input  wire twbpe_pkg::twbpe_word_t wr_word,
    output logic                       wr_ready,
    // read data stream
    output logic                       rd_valid,
    output logic [7:0]                 rd_data,
    // status
    output logic                       nack_seen,
    output logic                       arb_lost,
    output logic                       bus_busy,
    output logic                       conflict,
    // bus pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output twbpe_pkg::twbpe_pins_t     pins
);
    // ************************************************************
    // line sampling
    // ************************************************************
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic       scl_d_reg, sda_d_reg;
    logic       scl_s, sda_s, scl_fall, start_det, stop_det;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    always_comb begin
        scl_s     = scl_sync_reg[1];
        sda_s     = sda_sync_reg[1];
        scl_fall  = scl_d_reg && !scl_s;
        start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    end

    // ************************************************************
    // transmit fifo
    // ************************************************************
    logic        f_valid, f_ready;
    logic [8:0]  f_data;

    twbpe_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) twbpe_fifo_inst (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_data   (wr_word),
        .in_ready  (wr_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // ************************************************************
    // protocol state
    // ************************************************************
    twbpe_pkg::twbpe_state_t st_reg, st_next;
    logic [15:0] tmr_reg, tmr_next;
    logic [3:0]  bit_reg, bit_next;
    logic [7:0]  sh_reg, sh_next;
    logic        rd_reg, rd_next, last_reg, last_next, addr_reg, addr_next;
    logic        busy_reg, busy_next, arb_reg, arb_next, nack_reg, nack_next;
    logic        conf_reg, conf_next, rv_reg, rv_next;
    logic [7:0]  rdd_reg, rdd_next;
    logic        scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic        cmdr_reg, cmdr_next, hold_reg, hold_next;
    logic        drive_bit;

    always_comb begin
        st_next     = st_reg;
        tmr_next    = tmr_reg;
        bit_next    = bit_reg;
        sh_next     = sh_reg;
        rd_next     = rd_reg;
        last_next   = last_reg;
        addr_next   = addr_reg;
        arb_next    = arb_reg;
        nack_next   = nack_reg;
        conf_next   = 1'b0;
        rv_next     = 1'b0;
        rdd_next    = rdd_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        f_ready     = 1'b0;
        hold_next   = hold_reg;
        drive_bit   = 1'b1;
        // any start seen on the bus, our own included, marks the bus busy, stop frees it
        busy_next   = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_reg);
        if (bit_reg < twbpe_pkg::ACK_BIT_IDX) begin
            drive_bit = (addr_reg || !rd_reg) ? sh_reg[7] : 1'b1;
        end else begin
            // a pending repeated start ends the read: nack so the slave lets go of sda
            drive_bit = (rd_reg && !addr_reg) ? (last_reg || cmd.start) : 1'b1;
        end
        cmdr_next = (st_reg == twbpe_pkg::TWBPE_IDLE) && !busy_reg && !cmd.start;
        case (st_reg)
            twbpe_pkg::TWBPE_IDLE: begin
                if (cmd.start && !busy_reg && !start_det && scl_s && sda_s) begin
                    sh_next     = {cmd.addr, cmd.read};
                    rd_next     = cmd.read;
                    addr_next   = 1'b1;
                    bit_next    = '0;
                    arb_next    = 1'b0;
                    nack_next   = 1'b0;
                    hold_next   = 1'b0;
                    sda_oe_next = 1'b1;
                    tmr_next    = 16'(HIGH_CYCLES);
                    st_next     = twbpe_pkg::TWBPE_START;
                end
            end
            twbpe_pkg::TWBPE_RSTART: begin
                // scl high, sda released: drop sda to mark repeated start
                if (scl_s && tmr_reg == '0) begin
                    sda_oe_next = 1'b1;
                    tmr_next    = 16'(HIGH_CYCLES);
                    st_next     = twbpe_pkg::TWBPE_START;
                end else if (scl_s) begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_START: begin
                if (tmr_reg == '0) begin
                    scl_oe_next = 1'b1;
                    tmr_next    = 16'(LOW_CYCLES);
                    st_next     = twbpe_pkg::TWBPE_LOW;
                end else begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_LOW: begin
                // data changes only in the low phase
                sda_oe_next = !drive_bit;
                if (tmr_reg == '0) begin
                    scl_oe_next = 1'b0;
                    st_next     = twbpe_pkg::TWBPE_STRETCH;
                end else begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_STRETCH: begin
                // wait while anyone else holds scl low
                if (scl_s) begin
                    tmr_next = 16'(HIGH_CYCLES);
                    st_next  = twbpe_pkg::TWBPE_HIGH;
                end
            end
            twbpe_pkg::TWBPE_HIGH: begin
                if (start_det || stop_det) begin
                    conf_next   = 1'b1;
                    arb_next    = 1'b1;
                    sda_oe_next = 1'b0;
                    st_next     = twbpe_pkg::TWBPE_LOST;
                end else if (!scl_s) begin
                    // somebody else ended our high phase early
                    tmr_next = 16'(LOW_CYCLES);
                    st_next  = twbpe_pkg::TWBPE_LOW;
                end else if (!sda_oe_reg && !sda_s
                             && ((bit_reg < twbpe_pkg::ACK_BIT_IDX)
                             == (addr_reg || !rd_reg))) begin
                    arb_next    = 1'b1;
                    sda_oe_next = 1'b0;
                    st_next     = twbpe_pkg::TWBPE_LOST;
                end else if (tmr_reg == '0) begin
                    scl_oe_next = 1'b1;
                    tmr_next    = 16'(LOW_CYCLES);
                    st_next     = twbpe_pkg::TWBPE_LOW;
                    if (bit_reg == twbpe_pkg::ACK_BIT_IDX) begin
                        bit_next  = '0;
                        addr_next = 1'b0;
                        if (rd_reg && !addr_reg) begin
                            rv_next  = 1'b1;
                            rdd_next = sh_reg;
                        end
                        if (!rd_reg || addr_reg) begin
                            nack_next = sda_s;
                        end
                        // byte-level decision point: stop, load the next byte, stall for data or repeated start
                        if (sda_s && (!rd_reg || addr_reg)) begin
                            st_next = twbpe_pkg::TWBPE_STOP_A;
                        end else if (rd_reg && !addr_reg && last_reg) begin
                            st_next = twbpe_pkg::TWBPE_STOP_A;
                        end else if (!rd_reg && f_valid) begin
                            f_ready   = 1'b1;
                            sh_next   = f_data[7:0];
                            last_next = f_data[8];
                        end else if (!rd_reg && (last_reg || addr_reg)) begin
                            st_next = twbpe_pkg::TWBPE_STOP_A;
                        end else if (!rd_reg) begin
                            // no data yet: stretch before the next byte
                            bit_next = twbpe_pkg::ACK_BIT_IDX;
                            tmr_next = '0;
                            st_next  = twbpe_pkg::TWBPE_LOW;
                            hold_next = !cmd.start;
                            if (cmd.start) begin
                                st_next = twbpe_pkg::TWBPE_RSTART;
                            end
                        end else begin
                            last_next = 1'b0;
                        end
                        if (rd_reg && !addr_reg && cmd.start) begin
                            st_next = twbpe_pkg::TWBPE_RSTART;
                        end
                    end else begin
                        bit_next = bit_reg + 4'h1;
                        sh_next  = {sh_reg[6:0], sda_s};
                    end
                end else begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_STOP_A: begin
                // low phase with sda pulled, then release scl
                sda_oe_next = 1'b1;
                if (tmr_reg == '0) begin
                    scl_oe_next = 1'b0;
                    if (scl_s) begin
                        tmr_next = 16'(HIGH_CYCLES);
                        st_next  = twbpe_pkg::TWBPE_STOP_B;
                    end
                end else begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_STOP_B: begin
                if (tmr_reg == '0) begin
                    sda_oe_next = 1'b0;
                    last_next   = 1'b0;
                    st_next     = twbpe_pkg::TWBPE_IDLE;
                end else begin
                    tmr_next = tmr_reg - 16'h0001;
                end
            end
            twbpe_pkg::TWBPE_LOST: begin
                scl_oe_next = 1'b0;
                sda_oe_next = 1'b0;
                if (stop_det) begin
                    st_next = twbpe_pkg::TWBPE_IDLE;
                end
            end
            default: begin
                st_next = twbpe_pkg::TWBPE_IDLE;
            end
        endcase
        // stalled write: scl stays low until the next byte is queued or a repeated start is requested
        if (st_reg == twbpe_pkg::TWBPE_LOW && hold_reg && tmr_reg == '0) begin
            scl_oe_next = 1'b1;
            st_next     = twbpe_pkg::TWBPE_LOW;
            if (f_valid) begin
                f_ready   = 1'b1;
                sh_next   = f_data[7:0];
                last_next = f_data[8];
                bit_next  = '0;
                tmr_next  = 16'(LOW_CYCLES);
                hold_next = 1'b0;
            end else if (cmd.start) begin
                st_next   = twbpe_pkg::TWBPE_RSTART;
                hold_next = 1'b0;
            end
        end
        if (st_next == twbpe_pkg::TWBPE_RSTART && st_reg != twbpe_pkg::TWBPE_RSTART) begin
            sh_next   = {cmd.addr, cmd.read};
            rd_next   = cmd.read;
            addr_next = 1'b1;
            bit_next  = '0;
            tmr_next  = 16'(LOW_CYCLES);
        end
        if (st_reg == twbpe_pkg::TWBPE_RSTART && !scl_s) begin
            sda_oe_next = 1'b0;
            scl_oe_next = (tmr_reg != '0);
            tmr_next    = (tmr_reg == '0) ? tmr_reg : tmr_reg - 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg     <= twbpe_pkg::TWBPE_IDLE;
            tmr_reg    <= twbpe_pkg::LOW_CNT_RST;
            bit_reg    <= '0;
            sh_reg     <= twbpe_pkg::BYTE_RST;
            rd_reg     <= 1'b0;
            last_reg   <= 1'b0;
            addr_reg   <= 1'b0;
            busy_reg   <= 1'b0;
            arb_reg    <= 1'b0;
            nack_reg   <= 1'b0;
            conf_reg   <= 1'b0;
            rv_reg     <= 1'b0;
            rdd_reg    <= twbpe_pkg::BYTE_RST;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            cmdr_reg   <= 1'b0;
            hold_reg   <= 1'b0;
        end else begin
            st_reg     <= st_next;
            tmr_reg    <= tmr_next;
            bit_reg    <= bit_next;
            sh_reg     <= sh_next;
            rd_reg     <= rd_next;
            last_reg   <= last_next;
            addr_reg   <= addr_next;
            busy_reg   <= busy_next;
            arb_reg    <= arb_next;
            nack_reg   <= nack_next;
            conf_reg   <= conf_next;
            rv_reg     <= rv_next;
            rdd_reg    <= rdd_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            cmdr_reg   <= cmdr_next;
            hold_reg   <= hold_next;
        end
    end

    assign cmd_ready   = cmdr_reg;
    assign rd_valid    = rv_reg;
    assign rd_data     = rdd_reg;
    assign nack_seen   = nack_reg;
    assign arb_lost    = arb_reg;
    assign bus_busy    = busy_reg;
    assign conflict    = conf_reg;
    assign pins.scl_o  = 1'b0;
    assign pins.sda_o  = 1'b0;
    assign pins.scl_oe = scl_oe_reg;
    assign pins.sda_oe = sda_oe_reg;

    // ************************************************************
    // checks
    // ************************************************************
    sda_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_reg == twbpe_pkg::TWBPE_HIGH && st_next == twbpe_pkg::TWBPE_HIGH)
        |-> sda_oe_next == sda_oe_reg)
        else $error("sda changed during scl high");
    lost_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(arb_reg) && !conf_reg |=> !sda_oe_reg ##1 !sda_oe_reg)
        else $error("sda still driven after arbitration loss");
    idle_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_IDLE && busy_reg |=> st_reg == twbpe_pkg::TWBPE_IDLE)
        else $error("start while bus busy");
    wait_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_STRETCH && !scl_s |=> st_reg != twbpe_pkg::TWBPE_HIGH)
        else $error("high phase began with scl low");
    release_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_LOW && tmr_reg == '0 && !hold_reg |=> !scl_oe_reg)
        else $error("scl not released after low period");
    lost_passive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_LOST ##1 st_reg == twbpe_pkg::TWBPE_LOST
        |-> !scl_oe_reg && !sda_oe_reg)
        else $error("lines driven while passive");
    stop_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_STOP_B && st_next == twbpe_pkg::TWBPE_IDLE
        |-> scl_s && !scl_oe_reg)
        else $error("stop without scl high");
    start_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_reg == twbpe_pkg::TWBPE_IDLE && st_next == twbpe_pkg::TWBPE_START
        |-> scl_s && sda_s && !scl_oe_reg)
        else $error("start without idle lines");
endmodule
`default_nettype wire

//--- tb/twbpe_slave_model.sv
// slave partner model on the shared two-wire bus
`default_nettype none
module twbpe_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    // bus lines, released lines are pulled up
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            scl_oe,
    output logic            sda_oe,
    // control and capture
    input  wire logic       stretch,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      got,
    output logic            got_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic [7:0] sh  = 8'h00;
    logic [7:0] tx  = 8'h00;
    logic       adr = 1'b0;
    logic       rd  = 1'b0;
    logic       sel = 1'b0;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        got = 8'h00;
        got_stb = 1'b0;
    end
    always @(negedge sda) if (scl) begin
        cnt = -1;
        adr = 1'b1;
        sel = 1'b0;
    end
    always @(posedge sda) if (scl) sel = 1'b0;
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else if (rd && !adr && sda) sel = 1'b0;
    end
    // hold time after the falling edge keeps sda changes inside the low phase
    always @(negedge scl) begin
        cnt = cnt + 1;
        #24;
        if (cnt == 8 && adr) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
        end
        got = sh;
        got_stb = (cnt == 8 && sel && !adr && !rd);
        if (cnt == 9) begin
            cnt = 0;
            adr = 1'b0;
            tx = tx_byte;
        end
        if (cnt == 8) sda_oe = sel && (adr || !rd);
        else sda_oe = sel && rd && !adr && !tx[7-cnt];
        if (stretch && sel && cnt == 0) begin
            scl_oe = 1'b1;
            #400;
            scl_oe = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- tb/test_twbpe_engine.sv
// self-checking bench for the two-wire bus engine against a slave model
`default_nettype none
module test_twbpe_engine;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   core_clk = 1'b0;
    logic                   rst_n = 1'b0;
    twbpe_pkg::twbpe_cmd_t  cmd = '0;
    logic                   wr_valid = 1'b0;
    twbpe_pkg::twbpe_word_t wr_word = '0;
    logic                   cmd_ready, wr_ready, rd_valid, nack_seen, arb_lost, bus_busy;
    logic [7:0]             rd_data, got;
    twbpe_pkg::twbpe_pins_t pins;
    logic                   s_scl_oe, s_sda_oe, got_stb;
    logic                   m2_sda_oe = 1'b0;
    logic                   stretch = 1'b0;
    wire logic              scl = !(pins.scl_oe || s_scl_oe);
    wire logic              sda = !(pins.sda_oe || s_sda_oe || m2_sda_oe);
    int                     error_cnt = 0;
    int                     check_count = 0;
    int                     starts = 0;
    logic [7:0]             rxq[$];
    always #4 core_clk = ~core_clk;
    always @(negedge sda) if (scl) starts++;
    always @(posedge got_stb) rxq.push_back(got);
    twbpe_engine #(.LOW_CYCLES(10), .HIGH_CYCLES(10), .FIFO_DEPTH(16)) twbpe_engine_inst (
        .core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .cmd_ready(cmd_ready),
        .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .nack_seen(nack_seen), .arb_lost(arb_lost), .bus_busy(bus_busy),
        .conflict(), .scl_i(scl), .sda_i(sda), .pins(pins));
    twbpe_slave_model #(.ADDR(7'h2A)) twbpe_slave_model_inst (
        .scl(scl), .sda(sda), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .stretch(stretch),
        .tx_byte(8'hC3), .got(got), .got_stb(got_stb));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // start request is held until the start shows on the wires
    task automatic go(input logic [6:0] a, input logic r);
        int s;
        s = starts;
        @(negedge core_clk);
        cmd = '{1'b1, a, r};
        for (int i = 0; i < 4000 && starts == s; i++) @(negedge core_clk);
        chk_bit(starts != s, 1'b1);
        cmd.start = 1'b0;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 9000 && (bus_busy || !cmd_ready); i++) @(negedge core_clk);
        chk_bit(bus_busy || !cmd_ready, 1'b0);
    endtask
    task automatic push(input logic [7:0] d, input logic l);
        @(negedge core_clk);
        wr_word = '{l, d};
        wr_valid = 1'b1;
        for (int i = 0; i < 4000 && !wr_ready; i++) @(negedge core_clk);
        chk_bit(wr_ready, 1'b1);
        @(negedge core_clk);
        wr_valid = 1'b0;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_fifo_write();
        stretch = 1'b1;
        for (int i = 0; i < 16; i++) push(8'hA0 + 8'(i), i == 15);
        chk_bit(wr_ready, 1'b0);
        go(7'h2A, 1'b0);
        wait_idle();
        chk_byte(8'(rxq.size()), 8'h10);
        for (int i = 0; i < 16; i++) chk_byte(rxq[i], 8'hA0 + 8'(i));
        chk_bit(nack_seen, 1'b0);
        stretch = 1'b0;
        $display("fifo write done");
    endtask
    task automatic t_nack();
        go(7'h11, 1'b0);
        wait_idle();
        chk_bit(nack_seen, 1'b1);
        chk_bit(bus_busy, 1'b0);
        $display("address nack done");
    endtask
    task automatic t_combined();
        rxq.delete();
        push(8'h5A, 1'b1);
        go(7'h2A, 1'b1);
        for (int i = 0; i < 4000 && !rd_valid; i++) @(negedge core_clk);
        chk_byte(rd_data, 8'hC3);
        go(7'h2A, 1'b0);
        wait_idle();
        chk_byte(rxq[0], 8'h5A);
        chk_bit(nack_seen, 1'b0);
        $display("combined done");
    endtask
    task automatic t_arbitration();
        go(7'h7F, 1'b0);
        for (int i = 0; i < 400 && scl; i++) @(negedge core_clk);
        m2_sda_oe = 1'b1;
        for (int i = 0; i < 400 && !arb_lost; i++) @(negedge core_clk);
        chk_bit(arb_lost, 1'b1);
        chk_bit(pins.sda_oe, 1'b0);
        chk_bit(cmd_ready, 1'b0);
        for (int i = 0; i < 400 && !scl; i++) @(negedge core_clk);
        m2_sda_oe = 1'b0;
        wait_idle();
        chk_bit(bus_busy, 1'b0);
        $display("arbitration done");
    endtask
    // address-only write, then a write that stalls between bytes
    task automatic t_short_write();
        rxq.delete();
        go(7'h2A, 1'b0);
        wait_idle();
        chk_byte(8'(rxq.size()), 8'h00);
        chk_bit(nack_seen, 1'b0);
        push(8'h3C, 1'b0);
        go(7'h2A, 1'b0);
        repeat (800) @(negedge core_clk);
        chk_bit(scl, 1'b0);
        push(8'h96, 1'b1);
        wait_idle();
        chk_byte(8'(rxq.size()), 8'h02);
        chk_byte(rxq[0], 8'h3C);
        chk_byte(rxq[1], 8'h96);
        $display("short write done");
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        chk_bit(pins.scl_oe | pins.sda_oe | cmd_ready, 1'b0);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk_bit(cmd_ready, 1'b1);
        $display("reset done");
        t_fifo_write();
        t_nack();
        t_combined();
        t_arbitration();
        t_short_write();
        report_and_stop();
    end
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
